// ===== rtl/csp_core_support.sv
// Context shadows, return stack, program counter and indirect pointers
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module csp_core_support (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [csp_pkg::WB_AW-1:0] wbAdr,
	input wire logic [csp_pkg::WB_DW-1:0] wbWrDat,
	output logic [csp_pkg::WB_DW-1:0] wbRdDat,
	input wire logic wbWe,
	input wire logic [3:0] wbSel,
	input wire logic wbCyc,
	input wire logic wbStb,
	output logic wbAck,
	output logic irq,
	output logic seqReady,
	input wire logic stepPc,
	input wire logic callReq,
	input wire logic [csp_pkg::PC_W-1:0] callTarget,
	input wire logic retReq,
	input wire logic retfieReq,
	input wire logic intReq,
	output logic [csp_pkg::PC_W-1:0] pc,
	input wire logic [7:0] liveW,
	input wire logic [4:0] liveStatus,
	input wire logic [4:0] liveBsr,
	input wire logic [6:0] livePclath,
	output logic [7:0] shadowW,
	output logic [4:0] shadowStatus,
	output logic [4:0] shadowBsr,
	output logic [6:0] shadowPclath,
	output logic ctxRestore,
	input wire logic indReq,
	input wire logic indSel,
	input wire logic indWe,
	input wire logic [csp_pkg::BYTE_W-1:0] indWdata,
	output logic indReady,
	output logic indAck,
	output logic [csp_pkg::BYTE_W-1:0] indRdata,
	output logic dataReq,
	output logic dataWe,
	output logic [csp_pkg::DADDR_W-1:0] dataAddr,
	output logic [csp_pkg::BYTE_W-1:0] dataWdata,
	input wire logic [csp_pkg::BYTE_W-1:0] dataRdata,
	output logic progReq,
	output logic [csp_pkg::PC_W-1:0] progAddr,
	input wire logic [csp_pkg::PROG_W-1:0] progRdata,
	output logic swReset
);

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	function automatic csp_pkg::csp_kind_t ptrKind(
		input logic [csp_pkg::PTR_W-1:0] p);
		if (p[csp_pkg::PROG_BIT]) begin
			ptrKind = csp_pkg::K_PROG;
		end else if (p <= csp_pkg::TRAD_LAST) begin
			ptrKind = csp_pkg::K_TRAD;
		end else if (p >= csp_pkg::LIN_BASE && p <= csp_pkg::LIN_LAST) begin
			ptrKind = csp_pkg::K_LIN;
		end else begin
			ptrKind = csp_pkg::K_NONE;
		end
	endfunction : ptrKind

	// Linear offset splits into bank and in-bank GPR offset
	function automatic logic [csp_pkg::DADDR_W-1:0] ptrMap(
		input logic [csp_pkg::PTR_W-1:0] p);
		logic [csp_pkg::PTR_W-1:0] lin;
		logic [csp_pkg::PTR_W-1:0] bank;
		logic [csp_pkg::PTR_W-1:0] rem;
		lin = p - csp_pkg::LIN_BASE;
		bank = lin / csp_pkg::BANK_BYTES;
		rem = lin % csp_pkg::BANK_BYTES;
		if (p <= csp_pkg::TRAD_LAST) begin
			ptrMap = p[csp_pkg::DADDR_W-1:0];
		end else begin
			ptrMap = {bank[4:0], csp_pkg::GPR_OFF + rem[6:0]};
		end
	endfunction : ptrMap

	function automatic logic [csp_pkg::WB_AW-1:0] ptrOff(input int i);
		ptrOff = csp_pkg::OFF_PTR0 + csp_pkg::PTR_STRIDE * i[7:0];
	endfunction : ptrOff

	////////////////////////////////////////////////////////////////////////
	// Declarations

	csp_pkg::csp_state_t stateQ;
	csp_pkg::csp_kind_t kindQ;
	logic [csp_pkg::PC_W-1:0] pcQ;
	logic [csp_pkg::DEPTH_W-1:0] depthQ;
	logic [csp_pkg::PTR_W-1:0] ptrQ [2];
	logic [csp_pkg::PTR_W-1:0] ptrShadowQ [2];
	logic [csp_pkg::PC_W-1:0] stkRdData;
	logic [1:0] statusQ;
	logic [1:0] maskQ;
	logic errRstEnQ;
	logic popEmptyQ;
	logic swResetQ;
	logic ctxRestoreQ;
	logic wbAckQ;
	logic [csp_pkg::WB_DW-1:0] wbRdDatQ;
	logic [csp_pkg::WB_DW-1:0] rdMux;
	logic weQ;
	logic [csp_pkg::BYTE_W-1:0] wdataQ;
	logic [csp_pkg::DADDR_W-1:0] dAddrQ;
	logic [csp_pkg::PC_W-1:0] pAddrQ;
	logic indAckQ;
	logic [csp_pkg::BYTE_W-1:0] indRdataQ;
	logic [7:0] shWQ;
	logic [4:0] shStatusQ;
	logic [4:0] shBsrQ;
	logic [6:0] shPclathQ;
	logic idle;
	logic anySeq;
	logic takeInt;
	logic takeRetfie;
	logic takeRet;
	logic takeCall;
	logic takeStep;
	logic takeInd;
	logic push;
	logic pop;
	logic stkFull;
	logic stkEmpty;
	logic ovfEvt;
	logic unfEvt;
	logic errRst;
	logic wbReq;
	logic wbWr;
	logic [csp_pkg::PTR_W-1:0] indPtr;
	logic [csp_pkg::PC_W-1:0] pushVal;

	////////////////////////////////////////////////////////////////////////
	// Sequencer arbitration; interrupt entry outranks everything

	assign idle = stateQ == csp_pkg::ST_IDLE;
	assign anySeq = intReq | retfieReq | retReq | callReq | stepPc;
	assign takeInt = idle & intReq;
	assign takeRetfie = idle & !intReq & retfieReq;
	assign takeRet = idle & !intReq & !retfieReq & retReq;
	assign takeCall = idle & !intReq & !retfieReq & !retReq & callReq;
	assign takeStep = idle & !intReq & !retfieReq & !retReq & !callReq
		& stepPc;
	assign takeInd = idle & !anySeq & indReq;
	assign seqReady = idle;
	assign indReady = idle & !anySeq;

	assign push = takeInt | takeCall;
	assign pop = takeRet | takeRetfie;
	assign stkFull = depthQ == csp_pkg::STK_DEPTH;
	assign stkEmpty = depthQ == '0;
	assign ovfEvt = push & stkFull;
	assign unfEvt = pop & stkEmpty;
	assign errRst = (ovfEvt | unfEvt) & errRstEnQ;
	// Interrupt returns to the interrupted instruction, call to the next
	assign pushVal = takeInt ? pcQ : pcQ + csp_pkg::PC_STEP;

	////////////////////////////////////////////////////////////////////////
	// Return stack

	csp_stack_mem u_stack (
		.clk(clk),
		.nrst(nrst),
		.we(push & !stkFull),
		.wrAddr(depthQ[csp_pkg::STK_AW-1:0]),
		.wrData(pushVal),
		.rdAddr(depthQ[csp_pkg::STK_AW-1:0] - 4'h1),
		.rdData(stkRdData)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			depthQ <= '0;
		end else if (errRst) begin
			depthQ <= '0;
		end else if (push & !stkFull) begin
			depthQ <= depthQ + 5'h01;
		end else if (pop & !stkEmpty) begin
			depthQ <= depthQ - 5'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			popEmptyQ <= 1'b0;
		end else if (pop) begin
			popEmptyQ <= stkEmpty;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Program counter; registered stack read needs one extra pop cycle

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pcQ <= csp_pkg::PC_RESET;
		end else if (errRst) begin
			pcQ <= csp_pkg::PC_RESET;
		end else if (takeInt) begin
			pcQ <= csp_pkg::PC_INT_VEC;
		end else if (takeCall) begin
			pcQ <= callTarget;
		end else if (takeStep) begin
			pcQ <= pcQ + csp_pkg::PC_STEP;
		end else if (stateQ == csp_pkg::ST_POP) begin
			pcQ <= popEmptyQ ? csp_pkg::PC_RESET : stkRdData;
		end
	end
	assign pc = pcQ;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			swResetQ <= 1'b0;
		end else begin
			swResetQ <= errRst;
		end
	end
	assign swReset = swResetQ;

	////////////////////////////////////////////////////////////////////////
	// Context shadows, no stack level used

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shWQ <= '0;
			shStatusQ <= '0;
			shBsrQ <= '0;
			shPclathQ <= '0;
		end else if (takeInt) begin
			shWQ <= liveW;
			shStatusQ <= liveStatus;
			shBsrQ <= liveBsr;
			shPclathQ <= livePclath;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctxRestoreQ <= 1'b0;
		end else begin
			ctxRestoreQ <= takeRetfie & !errRst;
		end
	end
	assign shadowW = shWQ;
	assign shadowStatus = shStatusQ;
	assign shadowBsr = shBsrQ;
	assign shadowPclath = shPclathQ;
	assign ctxRestore = ctxRestoreQ;

	////////////////////////////////////////////////////////////////////////
	// Register slave, ack one cycle after the strobe

	assign wbReq = wbCyc & wbStb & !wbAckQ;
	assign wbWr = wbReq & wbWe;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wbAckQ <= 1'b0;
		end else begin
			wbAckQ <= wbReq;
		end
	end
	assign wbAck = wbAckQ;

	always_comb begin
		rdMux = '0;
		if (wbAdr == csp_pkg::OFF_CTRL) begin
			rdMux[csp_pkg::CTRL_ERRRST_BIT] = errRstEnQ;
		end else if (wbAdr == csp_pkg::OFF_STATUS) begin
			rdMux[1:0] = statusQ;
		end else if (wbAdr == csp_pkg::OFF_MASK) begin
			rdMux[1:0] = maskQ;
		end else if (wbAdr == ptrOff(0)) begin
			rdMux[csp_pkg::PTR_W-1:0] = ptrQ[0];
		end else if (wbAdr == ptrOff(1)) begin
			rdMux[csp_pkg::PTR_W-1:0] = ptrQ[1];
		end else if (wbAdr == csp_pkg::OFF_STACK) begin
			rdMux[csp_pkg::STACK_DEPTH_LSB+:csp_pkg::DEPTH_W] = depthQ;
			rdMux[csp_pkg::STACK_PC_LSB+:csp_pkg::PC_W] = pcQ;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wbRdDatQ <= '0;
		end else if (wbReq) begin
			wbRdDatQ <= rdMux;
		end
	end
	assign wbRdDat = wbRdDatQ;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			errRstEnQ <= csp_pkg::CTRL_ERRRST_RESET;
			maskQ <= csp_pkg::MASK_RESET;
		end else if (wbWr & wbSel[0]) begin
			if (wbAdr == csp_pkg::OFF_CTRL) begin
				errRstEnQ <= wbWrDat[csp_pkg::CTRL_ERRRST_BIT];
			end else if (wbAdr == csp_pkg::OFF_MASK) begin
				maskQ <= wbWrDat[1:0];
			end
		end
	end

	// Event set wins over a same-cycle write-one clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			statusQ <= csp_pkg::STATUS_RESET;
		end else begin
			if (wbWr & wbSel[0] & (wbAdr == csp_pkg::OFF_STATUS)) begin
				statusQ <= (statusQ & ~wbWrDat[1:0]) | {unfEvt, ovfEvt};
			end else begin
				statusQ <= statusQ | {unfEvt, ovfEvt};
			end
		end
	end
	assign irq = |(statusQ & maskQ);

	////////////////////////////////////////////////////////////////////////
	// Indirect pointers, restored on interrupt return

	for (genvar i = 0; i < 2; i++) begin : g_ptr
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				ptrShadowQ[i] <= csp_pkg::PTR_RESET;
			end else if (takeInt) begin
				ptrShadowQ[i] <= ptrQ[i];
			end
		end
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				ptrQ[i] <= csp_pkg::PTR_RESET;
			end else if (takeRetfie & !errRst) begin
				ptrQ[i] <= ptrShadowQ[i];
			end else if (wbWr & (wbAdr == ptrOff(i))) begin
				if (wbSel[0]) begin
					ptrQ[i][7:0] <= wbWrDat[7:0];
				end
				if (wbSel[1]) begin
					ptrQ[i][15:8] <= wbWrDat[15:8];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Access sequencer

	assign indPtr = indSel ? ptrQ[1] : ptrQ[0];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stateQ <= csp_pkg::ST_IDLE;
		end else begin
			case (stateQ)
				csp_pkg::ST_IDLE: begin
					if (pop & !errRst) begin
						stateQ <= csp_pkg::ST_POP;
					end else if (takeInd) begin
						if (ptrKind(indPtr) == csp_pkg::K_PROG) begin
							stateQ <= csp_pkg::ST_PROG1;
						end else begin
							stateQ <= csp_pkg::ST_DACC;
						end
					end
				end
				csp_pkg::ST_PROG1: stateQ <= csp_pkg::ST_PROG2;
				default: stateQ <= csp_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			kindQ <= csp_pkg::K_NONE;
			weQ <= 1'b0;
			wdataQ <= '0;
			dAddrQ <= '0;
			pAddrQ <= '0;
		end else if (takeInd) begin
			kindQ <= ptrKind(indPtr);
			weQ <= indWe;
			wdataQ <= indWdata;
			dAddrQ <= ptrMap(indPtr);
			pAddrQ <= indPtr[csp_pkg::PC_W-1:0];
		end
	end

	// Unmapped pointer space reads zero and drops writes
	assign dataReq = (stateQ == csp_pkg::ST_DACC) & (kindQ != csp_pkg::K_NONE);
	assign dataWe = dataReq & weQ;
	assign dataAddr = dAddrQ;
	assign dataWdata = wdataQ;
	assign progReq = (stateQ == csp_pkg::ST_PROG1)
		| (stateQ == csp_pkg::ST_PROG2);
	assign progAddr = pAddrQ;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			indAckQ <= 1'b0;
		end else begin
			indAckQ <= (stateQ == csp_pkg::ST_DACC)
				| (stateQ == csp_pkg::ST_PROG2);
		end
	end

	// No program write path exists, so such writes only complete
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			indRdataQ <= '0;
		end else if (stateQ == csp_pkg::ST_PROG2) begin
			indRdataQ <= weQ ? '0 : progRdata[7:0];
		end else if (stateQ == csp_pkg::ST_DACC) begin
			indRdataQ <= (weQ | !dataReq) ? '0 : dataRdata;
		end
	end
	assign indAck = indAckQ;
	assign indRdata = indRdataQ;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_ctx_save: assert property (takeInt |=> shadowW == $past(liveW))
		else $error("shadow W not captured");
	a_ctx_restore: assert property (takeRetfie & !errRst |=>
		ctxRestore && ptrQ[0] == $past(ptrShadowQ[0]))
		else $error("context not restored");
	a_depth_bound: assert property (depthQ <= csp_pkg::STK_DEPTH)
		else $error("stack depth out of range");
	a_ovf_flag: assert property (ovfEvt |=> statusQ[0]
		&& (irq || !maskQ[0])) else $error("overflow flag not set");
	a_unf_flag: assert property (unfEvt |=> statusQ[1])
		else $error("underflow flag not set");
	a_err_reset: assert property (errRst |=> swReset && pc == 15'h0000
		&& depthQ == 5'h00) else $error("stack error reset missing");
	a_no_err_rst: assert property ((ovfEvt | unfEvt) & !errRstEnQ
		|=> !swReset) else $error("unexpected software reset");
	a_ptr_write: assert property (wbWr & wbSel[1] & wbSel[0]
		& wbAdr == 8'h0C & !takeRetfie |=> ptrQ[0] == $past(wbWrDat[15:0]))
		else $error("pointer write lost");
	a_data_timing: assert property (takeInd & !indPtr[15]
		|=> !indAck ##1 indAck) else $error("data access timing");
	a_prog_timing: assert property (takeInd & indPtr[15]
		|=> !indAck [*2] ##1 indAck) else $error("program access timing");
	a_lin_offset: assert property (dataReq & kindQ == csp_pkg::K_LIN
		|-> dataAddr[6:0] >= 7'h20 && dataAddr[6:0] < 7'h70)
		else $error("linear offset outside GPR");
	a_prog_byte: assert property (stateQ == csp_pkg::ST_PROG2 & !weQ
		|=> indRdata == $past(progRdata[7:0]) && !dataWe)
		else $error("program byte wrong");
	a_int_vector: assert property (takeInt & !errRst
		|=> pc == 15'h0004) else $error("interrupt vector wrong");
	a_call_return: assert property (takeCall & !stkFull ##1 takeRet
		|=> ##1 pc == $past(pc, 3) + 15'h0001)
		else $error("return address wrong");

	c_int_entry: cover property (takeInt ##[1:20] takeRetfie);
	c_overflow: cover property (ovfEvt);
	c_prog_read: cover property (takeInd & indPtr[15] ##3 indAck);
	c_lin_access: cover property (dataReq & kindQ == csp_pkg::K_LIN);

endmodule : csp_core_support

// ===== rtl/csp_pkg.sv
// Shared constants and types of the core stack and pointer support block
package csp_pkg;

	localparam int PC_W = 15;
	localparam int STK_AW = 4;
	localparam int DEPTH_W = 5;
	localparam int PTR_W = 16;
	localparam int BYTE_W = 8;
	localparam int DADDR_W = 12;
	localparam int PROG_W = 14;
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;

	localparam logic [DEPTH_W-1:0] STK_DEPTH = 5'h10;
	localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
	localparam logic [PC_W-1:0] PC_INT_VEC = 15'h0004;
	localparam logic [PC_W-1:0] PC_STEP = 15'h0001;

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [WB_AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [WB_AW-1:0] OFF_STATUS = 8'h04;
	localparam logic [WB_AW-1:0] OFF_MASK = 8'h08;
	localparam logic [WB_AW-1:0] OFF_PTR0 = 8'h0C;
	localparam logic [WB_AW-1:0] OFF_STACK = 8'h14;
	localparam logic [WB_AW-1:0] PTR_STRIDE = 8'h04;

	localparam int CTRL_ERRRST_BIT = 0;
	localparam int ST_OVF_BIT = 0;
	localparam int ST_UNF_BIT = 1;
	localparam int STACK_DEPTH_LSB = 0;
	localparam int STACK_PC_LSB = 16;

	localparam logic CTRL_ERRRST_RESET = 1'b1;
	localparam logic [1:0] STATUS_RESET = 2'h0;
	localparam logic [1:0] MASK_RESET = 2'h0;
	localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Pointer address space
	localparam int PROG_BIT = 15;
	localparam logic [PTR_W-1:0] TRAD_LAST = 16'h0FFF;
	localparam logic [PTR_W-1:0] LIN_BASE = 16'h2000;
	localparam logic [PTR_W-1:0] LIN_LAST = 16'h29AF;
	localparam logic [PTR_W-1:0] BANK_BYTES = 16'h0050;
	localparam logic [6:0] GPR_OFF = 7'h20;

	typedef enum {ST_IDLE, ST_POP, ST_DACC, ST_PROG1, ST_PROG2} csp_state_t;
	typedef enum {K_TRAD, K_LIN, K_PROG, K_NONE} csp_kind_t;

endpackage : csp_pkg

// ===== rtl/csp_stack_mem.sv
// Return address storage with registered read port
`timescale 1ns/1ps
module csp_stack_mem (
	input wire logic clk,
	input wire logic nrst,
	input wire logic we,
	input wire logic [csp_pkg::STK_AW-1:0] wrAddr,
	input wire logic [csp_pkg::PC_W-1:0] wrData,
	input wire logic [csp_pkg::STK_AW-1:0] rdAddr,
	output logic [csp_pkg::PC_W-1:0] rdData
);

	logic [csp_pkg::PC_W-1:0] mem [2**csp_pkg::STK_AW];

	// Array has no reset; an empty level is never returned
	always_ff @(posedge clk) begin
		if (we) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdData <= csp_pkg::PC_RESET;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule : csp_stack_mem

// ===== test/csp_core_support_tb.sv
// Self-checking bench of the core stack and pointer support block
`timescale 1ns/1ps
module testbench;

////////////////////////////////////////////////////////////////////////////
logic clk = 1'b0;
logic nrst = 1'b0;
logic [7:0] wbAdr = 8'h00;
logic [31:0] wbWrDat = 32'h0000_0000;
logic [31:0] wbRdDat;
logic wbWe = 1'b0;
logic [3:0] wbSel = 4'h0;
logic wbCyc = 1'b0;
logic wbStb = 1'b0;
logic wbAck, irq, seqReady, ctxRestore, swReset;
logic stepPc = 1'b0;
logic callReq = 1'b0;
logic retReq = 1'b0;
logic retfieReq = 1'b0;
logic intReq = 1'b0;
logic [14:0] callTarget = 15'h0000;
logic [14:0] pc, progAddr;
logic [7:0] liveW = 8'h00;
logic [4:0] liveStatus = 5'h00;
logic [4:0] liveBsr = 5'h00;
logic [6:0] livePclath = 7'h00;
logic [7:0] shadowW;
logic [4:0] shadowStatus, shadowBsr;
logic [6:0] shadowPclath;
logic indReq = 1'b0;
logic indSel = 1'b0;
logic indWe = 1'b0;
logic [7:0] indWdata = 8'h00;
logic indReady, indAck, dataReq, dataWe, progReq;
logic [7:0] indRdata, dataWdata;
logic [11:0] dataAddr;
// Fixed memory answers keep expectations simple
logic [7:0] dataRdata = 8'hA7;
logic [13:0] progRdata = 14'h2A5C;
int bad_count = 0;
int checks = 0;
int swCnt = 0;
int ctxCnt = 0;
int indN, progCnt;
logic sawData, sawWe, seqLow;
logic [11:0] gotDAddr;
logic [14:0] gotPAddr;
logic [7:0] gotWd, indRd;
logic [31:0] rd;

csp_core_support dut (.clk(clk), .nrst(nrst), .wbAdr(wbAdr),
	.wbWrDat(wbWrDat), .wbRdDat(wbRdDat), .wbWe(wbWe), .wbSel(wbSel),
	.wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .irq(irq),
	.seqReady(seqReady), .stepPc(stepPc), .callReq(callReq),
	.callTarget(callTarget), .retReq(retReq), .retfieReq(retfieReq),
	.intReq(intReq), .pc(pc), .liveW(liveW), .liveStatus(liveStatus),
	.liveBsr(liveBsr), .livePclath(livePclath), .shadowW(shadowW),
	.shadowStatus(shadowStatus), .shadowBsr(shadowBsr),
	.shadowPclath(shadowPclath), .ctxRestore(ctxRestore), .indReq(indReq),
	.indSel(indSel), .indWe(indWe), .indWdata(indWdata),
	.indReady(indReady), .indAck(indAck), .indRdata(indRdata),
	.dataReq(dataReq), .dataWe(dataWe), .dataAddr(dataAddr),
	.dataWdata(dataWdata), .dataRdata(dataRdata), .progReq(progReq),
	.progAddr(progAddr), .progRdata(progRdata), .swReset(swReset));

always #25 clk = ~clk;

// Pulses last one cycle, so count them where settled
always @(negedge clk) begin
	if (swReset === 1'b1) swCnt++;
	if (ctxRestore === 1'b1) ctxCnt++;
end

////////////////////////////////////////////////////////////////////////////
task automatic check(input string nm, input logic [31:0] e,
	input logic [31:0] g);
	checks++;
	if (g !== e) begin
		bad_count++;
		$display("[ERR] %s expected %h seen %h", nm, e, g);
	end
endtask : check

task automatic wbXfer(input logic [7:0] a, input logic w,
	input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
	@(posedge clk);
	wbCyc <= 1'b1;
	wbStb <= 1'b1;
	wbWe <= w;
	wbAdr <= a;
	wbWrDat <= d;
	wbSel <= s;
	// Only the watchdog ends a missing answer
	do begin
		@(negedge clk);
	end while (wbAck !== 1'b1);
	@(posedge clk);
	r = wbRdDat;
	wbCyc <= 1'b0;
	wbStb <= 1'b0;
	wbWe <= 1'b0;
endtask : wbXfer

task automatic wbw(input logic [7:0] a, input logic [31:0] d,
	input logic [3:0] s);
	logic [31:0] x;
	wbXfer(a, 1'b1, d, s, x);
endtask : wbw

task automatic wbr(input logic [7:0] a);
	wbXfer(a, 1'b0, 32'h0000_0000, 4'hF, rd);
endtask : wbr

// Codes: 0 step, 1 call, 2 return, 3 interrupt return, 4 interrupt
task automatic seq(input int k, input logic [14:0] t);
	do begin
		@(negedge clk);
	end while (seqReady !== 1'b1);
	@(posedge clk);
	callTarget <= t;
	case (k)
		0: stepPc <= 1'b1;
		1: callReq <= 1'b1;
		2: retReq <= 1'b1;
		3: retfieReq <= 1'b1;
		default: intReq <= 1'b1;
	endcase
	@(posedge clk);
	{stepPc, callReq, retReq, retfieReq, intReq} <= 5'h00;
	@(negedge clk);
	seqLow = (seqReady === 1'b0);
	if (k == 2 || k == 3) @(negedge clk);
endtask : seq

task automatic ind(input logic s, input logic w, input logic [7:0] wd,
	input logic [15:0] p);
	wbw(csp_pkg::OFF_PTR0 + (s ? csp_pkg::PTR_STRIDE : 8'h00),
		{16'h0000, p}, 4'h3);
	@(posedge clk);
	indReq <= 1'b1;
	indSel <= s;
	indWe <= w;
	indWdata <= wd;
	@(posedge clk);
	indReq <= 1'b0;
	indWe <= 1'b0;
	indN = 0;
	sawData = 1'b0;
	sawWe = 1'b0;
	progCnt = 0;
	do begin
		@(negedge clk);
		indN++;
		if (indN == 1) check("port busy", 1'b0, indReady);
		if (dataReq === 1'b1) begin
			sawData = 1'b1;
			sawWe = dataWe;
			gotDAddr = dataAddr;
			gotWd = dataWdata;
		end
		if (progReq === 1'b1) begin
			progCnt++;
			gotPAddr = progAddr;
		end
	end while (indAck !== 1'b1 && indN < 10);
	indRd = indRdata;
endtask : ind

task automatic expInd(input int n, input logic d, input logic [11:0] a,
	input logic [7:0] r);
	check("ack latency", n, indN);
	check("data request", d, sawData);
	if (d) check("data address", a, gotDAddr);
	check("read byte", r, indRd);
endtask : expInd

////////////////////////////////////////////////////////////////////////////
task automatic resetTest;
	check("pc after reset", csp_pkg::PC_RESET, pc);
	wbr(csp_pkg::OFF_CTRL);
	check("ctrl reset", 32'h0000_0001, rd);
	wbr(csp_pkg::OFF_STATUS);
	check("status reset", 32'h0000_0000, rd);
	wbr(csp_pkg::OFF_STACK);
	check("stack reset", 32'h0000_0000, rd);
	wbr(csp_pkg::OFF_PTR0 + csp_pkg::PTR_STRIDE);
	check("pointer reset", 32'h0000_0000, rd);
	wbw(8'hFC, 32'hFFFF_FFFF, 4'hF);
	wbr(8'hFC);
	check("unmapped read", 32'h0000_0000, rd);
endtask : resetTest

task automatic indTest;
	ind(1'b0, 1'b0, 8'h00, 16'h0123);
	expInd(2, 1'b1, 12'h123, 8'hA7);
	ind(1'b0, 1'b1, 8'h55, 16'h0123);
	check("write strobe", 1'b1, sawWe);
	check("write byte", 8'h55, gotWd);
	check("write latency", 2, indN);
	ind(1'b1, 1'b0, 8'h00, 16'h2055);
	expInd(2, 1'b1, 12'h0A5, 8'hA7);
	ind(1'b1, 1'b0, 8'h00, 16'h29AF);
	expInd(2, 1'b1, 12'hF6F, 8'hA7);
	ind(1'b1, 1'b0, 8'h00, 16'h29B0);
	expInd(2, 1'b0, 12'h000, 8'h00);
	ind(1'b0, 1'b0, 8'h00, 16'h8123);
	expInd(3, 1'b0, 12'h000, 8'h5C);
	check("program fetch cycles", 2, progCnt);
	check("program address", 15'h0123, gotPAddr);
	ind(1'b0, 1'b1, 8'h33, 16'h8123);
	expInd(3, 1'b0, 12'h000, 8'h00);
	wbr(csp_pkg::OFF_PTR0 + csp_pkg::PTR_STRIDE);
	check("second pointer kept", 32'h0000_29B0, rd);
endtask : indTest

task automatic intTest;
	int c;
	wbw(csp_pkg::OFF_PTR0, 32'h0000_0123, 4'h3);
	seq(0, 15'h0000);
	check("pc step", 15'h0001, pc);
	liveW <= 8'hC3;
	liveStatus <= 5'h15;
	liveBsr <= 5'h0A;
	livePclath <= 7'h5A;
	seq(4, 15'h0000);
	check("interrupt vector", csp_pkg::PC_INT_VEC, pc);
	check("shadow context", {8'hC3, 5'h15, 5'h0A, 7'h5A},
		{shadowW, shadowStatus, shadowBsr, shadowPclath});
	wbr(csp_pkg::OFF_STACK);
	check("interrupt push", 32'h0004_0001, rd);
	liveW <= 8'h00;
	wbw(csp_pkg::OFF_PTR0, 32'h0000_0042, 4'h3);
	c = ctxCnt;
	seq(3, 15'h0000);
	check("restore pulse", c + 1, ctxCnt);
	check("return address", 15'h0001, pc);
	check("shadow held", 8'hC3, shadowW);
	wbr(csp_pkg::OFF_PTR0);
	check("pointer restored", 32'h0000_0123, rd);
endtask : intTest

task automatic callTest;
	seq(1, 15'h0300);
	check("call target", 15'h0300, pc);
	seq(2, 15'h0000);
	check("pop stall", 1'b1, seqLow);
	check("return pc", 15'h0002, pc);
	// Return taken in the cycle right after the call
	@(posedge clk);
	callReq <= 1'b1;
	callTarget <= 15'h0200;
	@(posedge clk);
	callReq <= 1'b0;
	retReq <= 1'b1;
	@(posedge clk);
	retReq <= 1'b0;
	repeat (2) @(negedge clk);
	check("back to back return", 15'h0003, pc);
endtask : callTest

task automatic limitTest;
	int s;
	wbw(csp_pkg::OFF_CTRL, 32'h0000_0000, 4'h1);
	wbw(csp_pkg::OFF_MASK, 32'h0000_0001, 4'h1);
	for (int i = 0; i < 16; i++) seq(1, 15'h7F00 + i[14:0]);
	wbr(csp_pkg::OFF_STACK);
	check("full depth", csp_pkg::STK_DEPTH, rd[4:0]);
	seq(1, 15'h0400);
	wbr(csp_pkg::OFF_STATUS);
	check("overflow flag", 32'h0000_0001, rd);
	check("irq unmasked", 1'b1, irq);
	wbw(csp_pkg::OFF_STATUS, 32'h0000_0001, 4'h1);
	check("irq cleared", 1'b0, irq);
	seq(2, 15'h0000);
	check("top entry", 15'h7F0F, pc);
	for (int i = 0; i < 15; i++) seq(2, 15'h0000);
	check("bottom entry", 15'h0004, pc);
	s = swCnt;
	seq(2, 15'h0000);
	check("underflow pc", 15'h0000, pc);
	wbr(csp_pkg::OFF_STATUS);
	check("underflow flag", 32'h0000_0002, rd);
	check("irq masked", 1'b0, irq);
	check("no reset when off", s, swCnt);
endtask : limitTest

task automatic errTest;
	int s;
	wbw(csp_pkg::OFF_CTRL, 32'h0000_0001, 4'h1);
	wbw(csp_pkg::OFF_STATUS, 32'h0000_0003, 4'h1);
	seq(1, 15'h0010);
	seq(2, 15'h0000);
	s = swCnt;
	seq(2, 15'h0000);
	check("software reset", s + 1, swCnt);
	check("pc cleared", 15'h0000, pc);
	wbr(csp_pkg::OFF_STATUS);
	check("flag kept", 32'h0000_0002, rd);
endtask : errTest

////////////////////////////////////////////////////////////////////////////
task automatic conclude;
	$display("Comparisons %0d, mismatches %0d", checks, bad_count);
	if (bad_count == 0 && checks > 0) begin
		$display("Test passed");
	end else begin
		$display("Test failed");
	end
	$finish;
endtask : conclude

initial begin
	repeat (20) @(posedge clk);
	nrst <= 1'b1;
	resetTest();
	indTest();
	intTest();
	callTest();
	limitTest();
	errTest();
	conclude();
end

// Whole run needs a few hundred cycles
initial begin
	#500_000;
	bad_count++;
	conclude();
end

endmodule : testbench
